//--- dv/global_liu_control_registers_tb.sv
// Self-checking bench for the global control register bank.
// Assumes glcr_pkg is compiled first; the bench plays APB master and channel bank.
`timescale 1ns/10ps
module global_liu_control_registers_tb
   import glcr_pkg::*;
;
   localparam logic [7:0] TB_PART = 8'hA5; // Arbitrary value
   localparam logic [3:0] TB_REV = 4'h3; // Arbitrary value
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] tx_pin = 3'h7;
   logic [2:0] chan_event = 3'h0;
   logic [2:0] rx_on;
   logic [2:0] tx_en;
   logic chan_sel;
   logic chan_write;
   logic [4:0] chan_addr;
   logic [7:0] chan_wdata;
   logic [7:0] chan_rdata = 8'h00;
   logic irq;
   logic [31:0] rdv;
   logic erv;
   logic [4:0] sel_addr = 5'h00;
   logic sel_wr = 1'b0;
   logic [7:0] sel_wd = 8'h00;
   logic [7:0] rsv[2] = '{8'h88, 8'hF4};
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;

   always #12.5 clock = ~clock;

   glcr_regs #(.PART_ID(TB_PART), .CHIP_REV(TB_REV)) i_dut (
      .CLOCK(clock), .RESET(reset), .CLK_EN(clk_en), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .TX_ENABLE_PIN(tx_pin),
      .CHAN_EVENT(chan_event), .RX_SECTION_ON(rx_on), .TX_DRIVER_EN(tx_en),
      .CHAN_SEL(chan_sel), .CHAN_WRITE(chan_write), .CHAN_ADDR(chan_addr),
      .CHAN_WDATA(chan_wdata), .CHAN_RDATA(chan_rdata), .IRQ(irq)
   );

   // Remember the last access forwarded to the channel bank
   always @(posedge clock)
   begin
      if (chan_sel === 1'b1)
      begin
         sel_addr <= chan_addr;
         sel_wr <= chan_write;
         sel_wd <= chan_wdata;
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         mismatches++;
         conclude();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; entered just after a rising edge, idles one cycle after
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1)
         @(posedge clock);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rdv, exp);
   endtask

   initial
   begin
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      check({29'h0, rx_on}, 32'h0);
      check({29'h0, tx_en}, 32'h0);
      rd_chk(8'h00, 32'h0);
      $display("reset test done");
      apb(1'b1, 8'h00, 32'hFFFF_FFFF);
      rd_chk(8'h00, 32'h77);
      repeat (6) @(posedge clock);
      check({29'h0, rx_on}, 32'h7);
      check({29'h0, tx_en}, 32'h7);
      apb(1'b1, 8'h00, 32'h25);
      rd_chk(8'h00, 32'h25);
      repeat (2) @(posedge clock);
      check({29'h0, rx_on}, 32'h2);
      check({29'h0, tx_en}, 32'h5);
      // Frozen block must not see the pin change
      clk_en <= 1'b0;
      tx_pin <= 3'h1;
      repeat (8) @(posedge clock);
      check({29'h0, tx_en}, 32'h5);
      clk_en <= 1'b1;
      repeat (8) @(posedge clock);
      check({29'h0, tx_en}, 32'h1);
      tx_pin <= 3'h7;
      repeat (8) @(posedge clock);
      $display("control test done");
      apb(1'b1, 8'h80, 32'hFF);
      rd_chk(8'h80, 32'h7);
      check({31'h0, irq}, 32'h0);
      chan_event <= 3'h2;
      @(posedge clock);
      chan_event <= 3'h0;
      repeat (3) @(posedge clock);
      check({31'h0, irq}, 32'h1);
      rd_chk(8'h84, 32'h2);
      apb(1'b1, 8'h84, 32'hFF);
      check({31'h0, erv}, 32'h0);
      rd_chk(8'h84, 32'h2);
      apb(1'b1, 8'h80, 32'h5);
      repeat (3) @(posedge clock);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, 8'h80, 32'h7);
      repeat (3) @(posedge clock);
      check({31'h0, irq}, 32'h1);
      $display("interrupt test done");
      rd_chk(8'hF8, {24'h0, TB_PART});
      rd_chk(8'hFC, {28'h0, TB_REV});
      apb(1'b1, 8'hF8, 32'h0);
      apb(1'b1, 8'hFC, 32'h0);
      rd_chk(8'hF8, {24'h0, TB_PART});
      rd_chk(8'hFC, {28'h0, TB_REV});
      $display("identity test done");
      chan_rdata <= 8'h3C;
      rd_chk(8'h04, 32'h3C);
      check({27'h0, sel_addr}, 32'h1);
      check({31'h0, sel_wr}, 32'h0);
      apb(1'b1, 8'h7C, 32'h96);
      check({27'h0, sel_addr}, 32'h1F);
      check({31'h0, sel_wr}, 32'h1);
      check({24'h0, sel_wd}, 32'h96);
      foreach (rsv[i])
      begin
         rd_chk(rsv[i], 32'h0);
         check({31'h0, erv}, 32'h1);
         apb(1'b1, rsv[i], 32'hFF);
         check({31'h0, erv}, 32'h1);
      end
      rd_chk(8'h00, 32'h25);
      rd_chk(8'h80, 32'h7);
      $display("address map test done");
      conclude();
   end
endmodule

//--- pkg/glcr_pkg.sv
// Constants for the global line-interface control register bank.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package glcr_pkg;
   localparam int GLCR_NCH = 3;
   localparam int GLCR_AW = 8;
   // Printed offsets are register indices; byte address is four times the index
   localparam logic [5:0] IDX_APS_CTRL = 6'h00;
   localparam logic [5:0] IDX_CHAN_LO = 6'h01;
   localparam logic [5:0] IDX_CHAN_HI = 6'h1F;
   localparam logic [5:0] IDX_BLK_IEN = 6'h20;
   localparam logic [5:0] IDX_BLK_IST = 6'h21;
   localparam logic [5:0] IDX_RSV_LO = 6'h22;
   localparam logic [5:0] IDX_RSV_HI = 6'h3D;
   localparam logic [5:0] IDX_PART_ID = 6'h3E;
   localparam logic [5:0] IDX_CHIP_REV = 6'h3F;
   localparam int ADDR_LSB = 2;
   // Field positions in the redundancy control register
   localparam int RX_ON_LSB = 4;
   localparam int TX_ON_LSB = 0;
   localparam logic [7:0] APS_CTRL_WMASK = 8'h77;
   localparam logic [7:0] APS_CTRL_RST = 8'h00;
   localparam logic [7:0] BLK_IEN_RST = 8'h00;
   localparam logic [2:0] BLK_IEN_WMASK = 3'h7;
endpackage

//--- rtl/glcr_regs.sv
// Global control register bank of a three-channel line interface unit.
// Assumes an APB master on CLOCK; per-channel bank sits outside on a side port.
//
// Functional notes
// - Redundancy control register at index 0x00, software read and write.
// - Block interrupt enable register at index 0x20, read and write.
// - Block interrupt status at index 0x21 is read-only; writes ignored.
// - Part number at 0x3E and chip revision at 0x3F, both read-only.
// - Indices 0x01-0x1F go to the channel bank; 0x22-0x3D are reserved.
// - Receive-on bits 6,5,4 for channels 2,1,0; one enables receive.
// - Receive-on zero powers down that channel's whole receive section.
// - Channel 2 transmit-on at bit 2; one enables its line driver while TX_ENABLE_PIN bit 2 is also high.
// - Channel 2 transmit-on zero tri-states both line output pins.
// - Transmit-on bits 1 and 0 for channels 1 and 0, same meaning.
`timescale 1ns/10ps
module glcr_regs
   import glcr_pkg::*;
#(
   parameter logic [7:0] PART_ID = 8'h5A, // Arbitrary value
   parameter logic [3:0] CHIP_REV = 4'h1  // Arbitrary value
) (
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic CLK_EN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [GLCR_AW-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [GLCR_NCH-1:0] TX_ENABLE_PIN,
   input wire logic [GLCR_NCH-1:0] CHAN_EVENT,
   output logic [GLCR_NCH-1:0] RX_SECTION_ON,
   output logic [GLCR_NCH-1:0] TX_DRIVER_EN,
   output logic CHAN_SEL,
   output logic CHAN_WRITE,
   output logic [4:0] CHAN_ADDR,
   output logic [7:0] CHAN_WDATA,
   input wire logic [7:0] CHAN_RDATA,
   output logic IRQ
);
   typedef struct packed {
      logic [7:0] aps_ctrl;
      logic [2:0] blk_ien;
      logic [2:0] blk_ist;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic [2:0] rx_on;
      logic [2:0] tx_en;
      logic chan_sel;
      logic chan_wr;
      logic [4:0] chan_addr;
      logic [7:0] chan_wdata;
      logic chan_wait;
      logic irq;
   } glcr_state_s;

   glcr_state_s st_q;
   glcr_state_s st_d;
   logic [GLCR_NCH-1:0] pin_en;
   logic [5:0] idx;
   logic acc;
   logic [2:0] rx_bits;
   logic [2:0] tx_bits;

   glcr_sync3 #(
      .W(GLCR_NCH)
   ) u_pin_sync (
      .clk(CLOCK),
      .rst(RESET),
      .ce(CLK_EN),
      .din(TX_ENABLE_PIN),
      .dout(pin_en)
   );

   assign idx = PADDR[ADDR_LSB +: 6];
   assign acc = PSEL && PENABLE && !st_q.ready;
   assign rx_bits = st_q.aps_ctrl[RX_ON_LSB +: GLCR_NCH];
   assign tx_bits = st_q.aps_ctrl[TX_ON_LSB +: GLCR_NCH];

   always_comb
   begin
      st_d = st_q;
      if (CLK_EN)
      begin
         st_d.ready = 1'b0;
         st_d.slverr = 1'b0;
         st_d.chan_sel = 1'b0;
         st_d.chan_wr = 1'b0;
         // Channel events are sticky; only reset clears them
         st_d.blk_ist = st_q.blk_ist | CHAN_EVENT;
         if (acc && !st_q.chan_wait)
         begin
            st_d.rdata = 32'h0000_0000;
            if (idx == IDX_APS_CTRL)
            begin
               st_d.ready = 1'b1;
               if (PWRITE)
               begin
                  st_d.aps_ctrl = PWDATA[7:0] & APS_CTRL_WMASK;
               end
               else
               begin
                  st_d.rdata = {24'h000000, st_q.aps_ctrl};
               end
            end
            else if (idx >= IDX_CHAN_LO && idx <= IDX_CHAN_HI)
            begin
               // One-cycle forward to the channel bank, answer on the next edge
               st_d.chan_sel = 1'b1;
               st_d.chan_wr = PWRITE;
               st_d.chan_addr = idx[4:0];
               st_d.chan_wdata = PWDATA[7:0];
               st_d.chan_wait = 1'b1;
            end
            else if (idx == IDX_BLK_IEN)
            begin
               st_d.ready = 1'b1;
               if (PWRITE)
               begin
                  st_d.blk_ien = PWDATA[2:0] & BLK_IEN_WMASK;
               end
               else
               begin
                  st_d.rdata = {29'h0000000, st_q.blk_ien};
               end
            end
            else if (idx == IDX_BLK_IST)
            begin
               st_d.ready = 1'b1;
               if (!PWRITE)
               begin
                  // Status is not writable; hardware sets, reads only report
                  st_d.rdata = {29'h0000000, st_q.blk_ist};
               end
            end
            else if (idx == IDX_PART_ID)
            begin
               st_d.ready = 1'b1;
               st_d.rdata = PWRITE ? 32'h0000_0000 : {24'h000000, PART_ID};
            end
            else if (idx == IDX_CHIP_REV)
            begin
               st_d.ready = 1'b1;
               st_d.rdata = PWRITE ? 32'h0000_0000 : {28'h0000000, CHIP_REV};
            end
            else
            begin
               // Reserved range 0x22-0x3D, the only indices left here: error, reads zero
               st_d.ready = 1'b1;
               st_d.slverr = 1'b1;
            end
         end
         else if (st_q.chan_wait)
         begin
            st_d.chan_wait = 1'b0;
            st_d.ready = 1'b1;
            st_d.rdata = st_q.chan_wr ? 32'h0000_0000 : {24'h000000, CHAN_RDATA};
         end
         st_d.rx_on = rx_bits;
         st_d.tx_en = tx_bits & pin_en;
         st_d.irq = |(st_q.blk_ist & st_q.blk_ien);
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         st_q <= '0;
         st_q.aps_ctrl <= APS_CTRL_RST;
         st_q.blk_ien <= BLK_IEN_RST[2:0];
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign PRDATA = st_q.rdata;
   assign PREADY = st_q.ready;
   assign PSLVERR = st_q.slverr;
   assign RX_SECTION_ON = st_q.rx_on;
   assign TX_DRIVER_EN = st_q.tx_en;
   assign CHAN_SEL = st_q.chan_sel;
   assign CHAN_WRITE = st_q.chan_wr;
   assign CHAN_ADDR = st_q.chan_addr;
   assign CHAN_WDATA = st_q.chan_wdata;
   assign IRQ = st_q.irq;

   property p_ctrl_write;
      @(posedge CLOCK) disable iff (RESET)
      (CLK_EN && acc && !st_q.chan_wait && PWRITE && idx == IDX_APS_CTRL)
         |=> (st_q.aps_ctrl == ($past(PWDATA[7:0]) & APS_CTRL_WMASK));
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

   property p_ien_write;
      @(posedge CLOCK) disable iff (RESET)
      (CLK_EN && acc && !st_q.chan_wait && PWRITE && idx == IDX_BLK_IEN)
         |=> (st_q.blk_ien == $past(PWDATA[2:0]));
   endproperty
   a_ien_write: assert property (p_ien_write) else $error("enable write lost");

   property p_ist_ro;
      @(posedge CLOCK) disable iff (RESET)
      (CLK_EN && acc && PWRITE && idx == IDX_BLK_IST)
         |=> (st_q.blk_ist == ($past(st_q.blk_ist) | $past(CHAN_EVENT)));
   endproperty
   a_ist_ro: assert property (p_ist_ro) else $error("status cleared by write");

   property p_part_id;
      @(posedge CLOCK) disable iff (RESET)
      (CLK_EN && acc && !st_q.chan_wait && !PWRITE && idx == IDX_PART_ID)
         |=> (PREADY && PRDATA == {24'h000000, PART_ID});
   endproperty
   a_part_id: assert property (p_part_id) else $error("bad part id read");

   property p_chan_fwd;
      @(posedge CLOCK) disable iff (RESET)
      (CLK_EN && acc && !st_q.chan_wait && idx >= IDX_CHAN_LO && idx <= IDX_CHAN_HI)
         |=> (CHAN_SEL && CHAN_ADDR == $past(idx[4:0]) && !PREADY);
   endproperty
   a_chan_fwd: assert property (p_chan_fwd) else $error("channel access not forwarded");

   property p_rx_follow;
      @(posedge CLOCK) disable iff (RESET)
      CLK_EN |=> (RX_SECTION_ON == $past(rx_bits));
   endproperty
   a_rx_follow: assert property (p_rx_follow) else $error("receive enable mismatch");

   property p_tx_and;
      @(posedge CLOCK) disable iff (RESET)
      (CLK_EN && !pin_en[2]) |=> !TX_DRIVER_EN[2];
   endproperty
   a_tx_and: assert property (p_tx_and) else $error("driver on with pin low");

   property p_tx_off;
      @(posedge CLOCK) disable iff (RESET)
      (CLK_EN && tx_bits == 3'h0) |=> (TX_DRIVER_EN == 3'h0);
   endproperty
   a_tx_off: assert property (p_tx_off) else $error("driver on with bit clear");

   property p_reset_clear;
      @(posedge CLOCK)
      RESET |=> (st_q.aps_ctrl == 8'h00 && RX_SECTION_ON == 3'h0 && TX_DRIVER_EN == 3'h0);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset left control set");

   property p_ctrl_read;
      @(posedge CLOCK) disable iff (RESET)
      (CLK_EN && acc && !st_q.chan_wait && !PWRITE && idx == IDX_APS_CTRL)
         |=> (PREADY && PRDATA == {24'h000000, $past(st_q.aps_ctrl)});
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

   property p_ist_read;
      @(posedge CLOCK) disable iff (RESET)
      (CLK_EN && acc && !st_q.chan_wait && !PWRITE && idx == IDX_BLK_IST)
         |=> (PREADY && PRDATA == {29'h0000000, $past(st_q.blk_ist)});
   endproperty
   a_ist_read: assert property (p_ist_read) else $error("status read wrong");

   property p_chip_rev;
      @(posedge CLOCK) disable iff (RESET)
      (CLK_EN && acc && !st_q.chan_wait && !PWRITE && idx == IDX_CHIP_REV)
         |=> (PREADY && PRDATA == {28'h0000000, CHIP_REV});
   endproperty
   a_chip_rev: assert property (p_chip_rev) else $error("bad revision read");

   property p_rsv_err;
      @(posedge CLOCK) disable iff (RESET)
      (CLK_EN && acc && !st_q.chan_wait && idx >= IDX_RSV_LO && idx <= IDX_RSV_HI)
         |=> (PREADY && PSLVERR && PRDATA == 32'h0000_0000);
   endproperty
   a_rsv_err: assert property (p_rsv_err) else $error("reserved access not refused");

   property p_rsvd_bits;
      @(posedge CLOCK) disable iff (RESET)
      ((st_q.aps_ctrl & ~APS_CTRL_WMASK) == 8'h00);
   endproperty
   a_rsvd_bits: assert property (p_rsvd_bits) else $error("reserved control bit set");

   property p_tx_on;
      @(posedge CLOCK) disable iff (RESET)
      (CLK_EN && tx_bits[2] && pin_en[2]) |=> TX_DRIVER_EN[2];
   endproperty
   a_tx_on: assert property (p_tx_on) else $error("driver off with bit and pin set");

   property p_irq;
      @(posedge CLOCK) disable iff (RESET)
      CLK_EN |=> (IRQ == |($past(st_q.blk_ist) & $past(st_q.blk_ien)));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt level mismatch");
endmodule

//--- rtl/glcr_sync3.sv
// Three-flop synchroniser for a pin-level input vector.
// Assumes the pin is asynchronous to CLOCK; stage one feeds stage two only.
`timescale 1ns/10ps
module glcr_sync3 #(
   parameter int W = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] val;
   } glcr_sync_s;

   glcr_sync_s st_q;
   glcr_sync_s st_d;

   always_comb
   begin
      st_d = st_q;
      if (ce)
      begin
         st_d.s1 = din;
         st_d.s2 = st_q.s1;
         st_d.s3 = st_q.s2;
         // Change counts only once stages two and three agree
         for (int i = 0; i < W; i++)
         begin
            if (st_q.s2[i] == st_q.s3[i])
            begin
               st_d.val[i] = st_q.s3[i];
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign dout = st_q.val;
endmodule
